//--- rtl/usub_bridge.sv
// Purpose: usb serial to uart bridge core with ahb-lite control registers
// Assumes: usb side delivers byte streams and a start-of-frame pulse on clk
// Notes:   slot counts must be powers of two
//
// Contract
// - baud clamped silently into 1200 bps .. 500 kbps
// - new baud takes effect on the fly, session continues
// - characters always carry eight data bits
// - parity selectable: odd, even or none
// - one or two stop bits sent and accepted
// - no handshake lines, only serial data pins
// - line settings read/write before session; data paths stay off
// - host raises dtr to open session; shifters and paths start
// - dtr low keeps shifters on, stops the receiver
// - after dtr low queued frames still sent, new data refused
// - file starting with command prefix sends following characters out
// - override message capped at fifty characters, rest dropped
// - override uses 9600 bps unless a rate was used before
// - host data handled in 64-byte frames queued per frame
// - at most four host frames outstanding, host throttled
// - target bytes packed into 64-byte frames, sent when full
// - partial receive frame flushed about every 100 ms via sof
// - at most seven receive frames in flight
// - overrun recycles last filled frame, whole frame lost
`timescale 1ns/1ps
module usub_bridge
  import usub_pkg::*;
#(
  parameter int TX_SLOTS = TX_SLOTS_D,
  parameter int RX_SLOTS = RX_SLOTS_D,
  parameter int OV_MAX   = OV_MAX_D
)(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  input  wire usub_byte_type h2t,
  input  wire logic          h2t_valid,
  output logic               h2t_ready,
  output usub_byte_type      t2h,
  output logic               t2h_valid,
  input  wire logic          t2h_ready,
  input  wire logic          sof_tick,
  input  wire usub_byte_type file_byte,
  input  wire logic          file_valid,
  output logic               file_ready,
  input  wire logic          bridge_serial_in_pin,
  output logic               bridge_serial_out_pin,
  output logic               level_shift_en
);
  localparam int IW  = $clog2(FRAME_BYTES);
  localparam int TSW = $clog2(TX_SLOTS);
  localparam int RSW = $clog2(RX_SLOTS);
  localparam int OW  = $clog2(OV_MAX + 1);
  localparam logic [IW-1:0]  LAST_IDX = IW'(FRAME_BYTES - 1);
  localparam logic [IW:0]    FULL_CNT = (IW + 1)'(FRAME_BYTES);
  localparam logic [TSW:0]   TX_FULL  = (TSW + 1)'(TX_SLOTS);
  localparam logic [RSW:0]   RX_LIM   = (RSW + 1)'(RX_SLOTS - 1);
  localparam logic [OW-1:0]  OV_LIM   = OW'(OV_MAX);
  localparam logic [6:0]     SOF_LAST = 7'(FLUSH_SOF - 1);

  typedef struct packed {
    logic [31:0]       hrdata;
    logic              hready;
    logic              wpend;
    logic [ADDR_W-1:0] waddr;
    logic              dtr;
    logic              shift_en;
    logic [BAUD_W-1:0] baud;
    logic [1:0]        parity;
    logic              stop2;
    logic              overrun;
    logic              perr;
    logic              h2t_ready;
    logic [TSW-1:0]    tw_slot;
    logic [TSW-1:0]    tr_slot;
    logic [IW-1:0]     tw_idx;
    logic [IW-1:0]     tr_idx;
    logic [TSW:0]      tx_cnt;
    usub_tx_st_type    t_st;
    logic [DIV_W-1:0]  t_cnt;
    logic              t_bit;
    logic [2:0]        t_n;
    logic [7:0]        t_sh;
    logic              t_par;
    logic              txo;
    logic              rs1;
    logic              rs2;
    usub_rx_st_type    r_st;
    logic [DIV_W-1:0]  r_cnt;
    logic [2:0]        r_n;
    logic [7:0]        r_sh;
    logic [RSW-1:0]    rw_slot;
    logic [RSW-1:0]    rr_slot;
    logic [IW:0]       rw_fill;
    logic [IW-1:0]     rr_idx;
    logic [RSW:0]      rx_cnt;
    logic [6:0]        sof_cnt;
    logic              t2h_valid;
    usub_byte_type     t2h;
    usub_ov_st_type    o_st;
    logic [3:0]        o_pidx;
    logic [OW-1:0]     o_len;
    logic [OW-1:0]     o_idx;
    logic              file_ready;
  } usub_state_type;

  usub_state_type    q;
  usub_state_type    d;
  logic [DIV_W-1:0]  div;
  logic [7:0]        tbyte;
  logic              par_on;
  logic              t_tick;
  logic              r_tick;
  logic              tx_we;
  logic              tx_push;
  logic              tx_pop;
  logic              rx_byte;
  logic              rx_close;
  logic              rx_push;
  logic              rx_pop;
  logic              ov_we;
  logic [IW:0]       rx_fill_v;
  logic [31:0]       rd;
  logic [7:0]        tx_mem [TX_SLOTS*FRAME_BYTES];
  logic [IW-1:0]     tx_len [TX_SLOTS];
  logic [7:0]        rx_mem [RX_SLOTS*FRAME_BYTES];
  logic [IW-1:0]     rx_len [RX_SLOTS];
  logic [7:0]        ov_mem [OV_MAX];

  // clamp a requested rate into the supported span
  function automatic logic [BAUD_W-1:0] clamp_baud(input logic [31:0] v);
    if (v < 32'(BAUD_MIN))
      return BAUD_MIN;
    else if (v > 32'(BAUD_MAX))
      return BAUD_MAX;
    else
      return v[BAUD_W-1:0];
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    tx_we = 1'b0;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_byte = 1'b0;
    rx_close = 1'b0;
    rx_push = 1'b0;
    rx_pop = 1'b0;
    ov_we = 1'b0;
    tbyte = 8'h00;
    rd = 32'h0000_0000;
    div = DIV_W'(CLK_HZ / 32'(q.baud));
    par_on = (q.parity == PAR_ODD) || (q.parity == PAR_EVEN);
    t_tick = (q.t_cnt >= div - 1'b1);
    r_tick = (q.r_cnt >= div - 1'b1);
    rx_fill_v = q.rw_fill;

    // bus data phase: register writes
    d.hready = 1'b1;
    if (q.wpend)
    begin
      case (q.waddr)
        REG_CTRL: d.dtr = hwdata[CTRL_DTR];
        REG_BAUD: d.baud = clamp_baud(hwdata);
        REG_FMT:
        begin
          d.parity = hwdata[FMT_PAR +: 2];
          d.stop2 = hwdata[FMT_STOP2];
        end
        REG_STAT:
        begin
          if (hwdata[ST_OVR])
            d.overrun = 1'b0;
          if (hwdata[ST_PERR])
            d.perr = 1'b0;
        end
        default: ;
      endcase
    end
    d.wpend = hsel && hready && htrans[1] && hwrite;
    d.waddr = {haddr[ADDR_W-1:2], 2'b00};
    if (d.dtr)
      d.shift_en = 1'b1;

    // host frames into transmit slots
    if (q.h2t_ready && h2t_valid)
    begin
      tx_we = 1'b1;
      d.tw_idx = q.tw_idx + 1'b1;
      if (h2t.last || q.tw_idx == LAST_IDX)
      begin
        tx_push = 1'b1;
        d.tw_idx = '0;
        d.tw_slot = q.tw_slot + 1'b1;
      end
    end

    // serial transmitter
    d.t_cnt = t_tick ? '0 : q.t_cnt + 1'b1;
    case (q.t_st)
      T_IDLE:
      begin
        d.txo = 1'b1;
        d.t_cnt = '0;
        if (q.o_st == O_SEND)
        begin
          tbyte = ov_mem[q.o_idx];
          d.t_st = T_START;
          d.o_idx = q.o_idx + 1'b1;
          if (q.o_idx == q.o_len - 1'b1)
          begin
            d.o_st = O_MATCH;
            d.o_pidx = '0;
          end
        end
        else if (q.tx_cnt != '0)
        begin
          tbyte = tx_mem[{q.tr_slot, q.tr_idx}];
          d.t_st = T_START;
          d.tr_idx = q.tr_idx + 1'b1;
          if (q.tr_idx == tx_len[q.tr_slot])
          begin
            tx_pop = 1'b1;
            d.tr_idx = '0;
            d.tr_slot = q.tr_slot + 1'b1;
          end
        end
        if (d.t_st == T_START)
        begin
          d.txo = 1'b0;
          d.t_sh = tbyte;
          d.t_par = (^tbyte) ^ (q.parity == PAR_ODD);
        end
      end
      T_START:
        if (t_tick)
        begin
          d.t_st = T_DATA;
          d.txo = q.t_sh[0];
          d.t_n = '0;
        end
      T_DATA:
        if (t_tick)
        begin
          d.t_sh = q.t_sh >> 1;
          d.txo = q.t_sh[1];
          d.t_n = q.t_n + 1'b1;
          if (q.t_n == 3'h7)
          begin
            d.t_st = par_on ? T_PAR : T_STOP;
            d.txo = par_on ? q.t_par : 1'b1;
            d.t_bit = 1'b0;
          end
        end
      T_PAR:
        if (t_tick)
        begin
          d.t_st = T_STOP;
          d.txo = 1'b1;
          d.t_bit = 1'b0;
        end
      T_STOP:
        if (t_tick)
        begin
          d.txo = 1'b1;
          if (q.stop2 && !q.t_bit)
            d.t_bit = 1'b1;
          else
            d.t_st = T_IDLE;
        end
      default: d.t_st = T_IDLE;
    endcase

    // serial receiver, only the data pin paces it
    d.rs1 = bridge_serial_in_pin;
    d.rs2 = q.rs1;
    d.r_cnt = q.r_cnt + 1'b1;
    case (q.r_st)
      R_IDLE:
      begin
        d.r_cnt = '0;
        if (!q.rs2)
          d.r_st = R_START;
      end
      R_START:
        if (q.r_cnt >= (div >> 1))
        begin
          d.r_cnt = '0;
          d.r_n = '0;
          d.r_st = q.rs2 ? R_IDLE : R_DATA;
        end
      R_DATA:
        if (r_tick)
        begin
          d.r_cnt = '0;
          d.r_sh = {q.rs2, q.r_sh[7:1]};
          d.r_n = q.r_n + 1'b1;
          if (q.r_n == 3'h7)
            d.r_st = par_on ? R_PAR : R_STOP;
        end
      R_PAR:
        if (r_tick)
        begin
          d.r_cnt = '0;
          d.r_st = R_STOP;
          if (((^q.r_sh) ^ q.rs2) != (q.parity == PAR_ODD))
            d.perr = 1'b1;
        end
      R_STOP:
        if (r_tick)
        begin
          d.r_st = R_IDLE;
          rx_byte = q.rs2;
        end
      default: d.r_st = R_IDLE;
    endcase
    if (!q.dtr)
    begin
      d.r_st = R_IDLE;
      rx_byte = 1'b0;
    end

    // receive frames: fill, flush, recycle on overrun
    if (rx_byte)
      rx_fill_v = q.rw_fill + 1'b1;
    if (sof_tick)
      d.sof_cnt = (q.sof_cnt == SOF_LAST) ? '0 : q.sof_cnt + 1'b1;
    rx_close = (rx_fill_v == FULL_CNT) ||
               (sof_tick && q.sof_cnt == SOF_LAST && rx_fill_v != '0);
    d.rw_fill = rx_fill_v;
    if (rx_close)
    begin
      d.rw_fill = '0;
      if (q.rx_cnt < RX_LIM)
      begin
        rx_push = 1'b1;
        d.rw_slot = q.rw_slot + 1'b1;
      end
      else
        d.overrun = 1'b1;
    end

    // drain queued receive frames toward the host
    if (!q.t2h_valid || t2h_ready)
    begin
      d.t2h_valid = 1'b0;
      if (q.rx_cnt != '0)
      begin
        d.t2h_valid = 1'b1;
        d.t2h.data = rx_mem[{q.rr_slot, q.rr_idx}];
        d.t2h.last = (q.rr_idx == rx_len[q.rr_slot]);
        d.rr_idx = q.rr_idx + 1'b1;
        if (d.t2h.last)
        begin
          rx_pop = 1'b1;
          d.rr_idx = '0;
          d.rr_slot = q.rr_slot + 1'b1;
        end
      end
    end
    d.rx_cnt = q.rx_cnt + {{RSW{1'b0}}, rx_push} - {{RSW{1'b0}}, rx_pop};
    d.tx_cnt = q.tx_cnt + {{TSW{1'b0}}, tx_push} - {{TSW{1'b0}}, tx_pop};

    // override file parser
    if (q.file_ready && file_valid)
    begin
      case (q.o_st)
        O_MATCH:
          if (file_byte.data == PREFIX[8*(PREFIX_LEN-1-32'(q.o_pidx)) +: 8])
          begin
            d.o_pidx = q.o_pidx + 1'b1;
            if (q.o_pidx == 4'(PREFIX_LEN - 1))
            begin
              d.o_st = O_CAPT;
              d.o_len = '0;
            end
          end
          else
            d.o_st = O_SKIP;
        O_CAPT:
          if (q.o_len < OV_LIM)
          begin
            ov_we = 1'b1;
            d.o_len = q.o_len + 1'b1;
          end
        default: ;
      endcase
      if (file_byte.last)
      begin
        d.o_pidx = '0;
        d.o_idx = '0;
        d.o_st = (d.o_st == O_CAPT && d.o_len != '0) ? O_SEND : O_MATCH;
      end
    end
    d.file_ready = (d.o_st != O_SEND);

    // host throttling and session gating
    d.h2t_ready = d.dtr && (d.tx_cnt < TX_FULL);

    // bus address phase: read data from the settled next state
    rd[CTRL_DTR] = d.dtr;
    if (d.waddr == REG_BAUD)
      rd[BAUD_W-1:0] = d.baud;
    else if (d.waddr == REG_FMT)
      rd[FMT_STOP2:0] = {d.stop2, d.parity};
    else if (d.waddr == REG_STAT)
    begin
      rd[ST_SHIFT] = d.shift_en;
      rd[ST_OVR] = d.overrun;
      rd[ST_PERR] = d.perr;
      rd[ST_OVSEND] = (d.o_st == O_SEND);
      rd[ST_TXCNT +: TSW+1] = d.tx_cnt;
      rd[ST_RXCNT +: RSW+1] = d.rx_cnt;
    end
    else if (d.waddr != REG_CTRL)
      rd = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite)
      d.hrdata = rd;
  end

  // ----------------------------------------
  // state and memories
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      q <= '0;
      q.hready <= 1'b1;
      q.baud <= BAUD_DEF;
      q.parity <= PAR_RST;
      q.txo <= 1'b1;
      q.rs1 <= 1'b1;
      q.rs2 <= 1'b1;
      q.file_ready <= 1'b1;
    end
    else
      q <= d;
  end

  // frame and message storage
  always_ff @(posedge clk)
  begin
    if (tx_we)
      tx_mem[{q.tw_slot, q.tw_idx}] <= h2t.data;
    if (tx_push)
      tx_len[q.tw_slot] <= q.tw_idx;
    if (rx_byte)
      rx_mem[{q.rw_slot, q.rw_fill[IW-1:0]}] <= q.r_sh;
    if (rx_push)
      rx_len[q.rw_slot] <= IW'(rx_fill_v - 1'b1);
    if (ov_we)
      ov_mem[q.o_len] <= file_byte.data;
  end

  assign hreadyout = q.hready;
  assign hrdata = q.hrdata;
  assign hresp = 1'b0;
  assign h2t_ready = q.h2t_ready;
  assign t2h = q.t2h;
  assign t2h_valid = q.t2h_valid;
  assign file_ready = q.file_ready;
  assign bridge_serial_out_pin = q.txo;
  assign level_shift_en = q.shift_en;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_baud_lim;
    @(posedge clk) disable iff (srst) (q.baud >= BAUD_MIN) && (q.baud <= BAUD_MAX);
  endproperty
  a_baud_lim: assert property (p_baud_lim) else $error("baud outside span");
  property p_ready_dtr;
    @(posedge clk) disable iff (srst) !q.dtr |-> !h2t_ready;
  endproperty
  a_ready_dtr: assert property (p_ready_dtr) else $error("data accepted without session");
  property p_tx_limit;
    @(posedge clk) disable iff (srst) (q.tx_cnt == TX_FULL) |-> !h2t_ready;
  endproperty
  a_tx_limit: assert property (p_tx_limit) else $error("host not throttled");
  property p_shift_on;
    @(posedge clk) disable iff (srst) $rose(q.dtr) |-> level_shift_en ##1 level_shift_en[*3];
  endproperty
  a_shift_on: assert property (p_shift_on) else $error("shifters not enabled");
  property p_rx_off;
    @(posedge clk) disable iff (srst) !q.dtr |=> q.r_st == R_IDLE;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver runs without session");
  property p_drain;
    @(posedge clk) disable iff (srst) !q.dtr |=> q.tx_cnt <= $past(q.tx_cnt);
  endproperty
  a_drain: assert property (p_drain) else $error("frame queued after session end");
  property p_start_bit;
    @(posedge clk) disable iff (srst) q.t_st == T_START |-> !bridge_serial_out_pin;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");
  property p_rx_lim;
    @(posedge clk) disable iff (srst) q.rx_cnt <= RX_LIM;
  endproperty
  a_rx_lim: assert property (p_rx_lim) else $error("too many receive frames");
  property p_recycle;
    @(posedge clk) disable iff (srst) rx_close && (q.rx_cnt == RX_LIM) && !rx_pop
      |=> q.overrun && (q.rx_cnt == RX_LIM) && (q.rw_fill == '0);
  endproperty
  a_recycle: assert property (p_recycle) else $error("overrun not recycled");
  property p_flush;
    @(posedge clk) disable iff (srst) sof_tick && (q.sof_cnt == SOF_LAST) && (q.rw_fill != '0)
      |=> q.rw_fill == '0;
  endproperty
  a_flush: assert property (p_flush) else $error("partial frame not flushed");
  property p_ov_len;
    @(posedge clk) disable iff (srst) q.o_len <= OV_LIM;
  endproperty
  a_ov_len: assert property (p_ov_len) else $error("override message too long");
endmodule

//--- rtl/usub_pkg.sv
// Purpose: shared constants and types of the usb serial uart bridge
// Assumes: 100 MHz system clock, usb start-of-frame every 1 ms
// Notes:   byte offsets of the register map are word aligned
package usub_pkg;
  // ----------------------------------------
  // clock, baud and framing
  // ----------------------------------------
  localparam int          CLK_HZ      = 100_000_000;
  localparam int          BAUD_W      = 19;
  localparam int          DIV_W       = 17;
  localparam logic [18:0] BAUD_MIN    = 19'h004b0;   // 1200 bps
  localparam logic [18:0] BAUD_MAX    = 19'h7a120;   // 500 kbps
  localparam logic [18:0] BAUD_DEF    = 19'h02580;   // 9600 bps
  localparam int          FRAME_BYTES = 64;
  localparam int          TX_SLOTS_D  = 4;
  localparam int          RX_SLOTS_D  = 8;
  localparam int          OV_MAX_D    = 50;
  localparam int          PREFIX_LEN  = 14;
  localparam logic [111:0] PREFIX     = "CMD:SEND UART=";
  localparam int          FLUSH_MS    = 100;
  localparam int          SOF_US      = 1000;
  localparam int          FLUSH_SOF   = FLUSH_MS * 1000 / SOF_US;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_BAUD    = 8'h04;
  localparam logic [7:0]  REG_FMT     = 8'h08;
  localparam logic [7:0]  REG_STAT    = 8'h0c;
  localparam int          ADDR_W      = 8;
  localparam int          CTRL_DTR    = 0;
  localparam int          FMT_PAR     = 0;
  localparam int          FMT_STOP2   = 2;
  localparam int          ST_SESSION  = 0;
  localparam int          ST_SHIFT    = 1;
  localparam int          ST_OVR      = 2;
  localparam int          ST_PERR     = 3;
  localparam int          ST_OVSEND   = 4;
  localparam int          ST_TXCNT    = 8;
  localparam int          ST_RXCNT    = 12;
  localparam logic [1:0]  PAR_NONE    = 2'h0;
  localparam logic [1:0]  PAR_ODD     = 2'h1;
  localparam logic [1:0]  PAR_EVEN    = 2'h2;
  localparam logic [1:0]  PAR_RST     = 2'h0;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } usub_byte_type;
  typedef enum logic [2:0] {T_IDLE, T_START, T_DATA, T_PAR, T_STOP} usub_tx_st_type;
  typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} usub_rx_st_type;
  typedef enum logic [1:0] {O_MATCH, O_CAPT, O_SKIP, O_SEND} usub_ov_st_type;
endpackage

//--- sim/usub_target.sv
// Purpose: target side uart model facing the bridge serial pins
// Assumes: bit time given in clk cycles by the caller
// Notes:   tasks are called right after a rising clk edge
`timescale 1ns/1ps
module usub_target
  import usub_pkg::*;
(
  input  wire logic clk,
  input  wire logic serial_out,
  output logic      serial_in
);
  int cyc = 0;

  // free cycle count used to time start edges
  always @(posedge clk) cyc <= cyc + 1;
  // line idles high, no handshake lines exist
  initial serial_in = 1'b1;

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ----------------------------------------
  // send one character toward the bridge
  // ----------------------------------------
  task automatic send(input int bc, input logic [1:0] par, input logic s2, input logic [7:0] d);
    serial_in <= 1'b0;
    wait_n(bc);
    for (int i = 0; i < 8; i++)
    begin
      serial_in <= d[i]; // lsb first
      wait_n(bc);
    end
    if (par == PAR_ODD || par == PAR_EVEN)
    begin
      serial_in <= ^d ^ (par == PAR_ODD);
      wait_n(bc);
    end
    serial_in <= 1'b1;
    wait_n(s2 ? 2 * bc : bc);
  endtask

  // ----------------------------------------
  // take one character from the bridge
  // ----------------------------------------
  task automatic recv(input int bc, input logic [1:0] par, input logic s2,
                      output logic [7:0] d, output logic ok, output int t0);
    int n;
    n = 0;
    while (serial_out !== 1'b0 && n < 30 * bc)
    begin
      @(posedge clk);
      n++;
    end
    t0 = cyc;
    ok = (n < 30 * bc);
    wait_n(bc / 2);
    for (int i = 0; i < 8; i++)
    begin
      wait_n(bc);
      d[i] = serial_out;
    end
    if (par == PAR_ODD || par == PAR_EVEN)
    begin
      wait_n(bc);
      ok = ok & (serial_out === (^d ^ (par == PAR_ODD)));
    end
    wait_n(bc);
    ok = ok & (serial_out === 1'b1);
    if (s2)
    begin
      wait_n(bc);
      ok = ok & (serial_out === 1'b1);
    end
  endtask
endmodule

//--- sim/test_usub_bridge.sv
// Purpose: self-checking bench of the usb serial uart bridge
// Assumes: zero wait state register bus, target model on the serial pins
// Notes:   bit times of 200 and 400 cycles keep the run short
`timescale 1ns/1ps
module test_usub_bridge;
  import usub_pkg::*;
  logic          clk = 0, srst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
  logic [31:0]   haddr = 0, hwdata = 0, hrdata, r;
  logic [1:0]    htrans = 0;
  logic [2:0]    hsize = 3'h2;
  usub_byte_type h2t = '0, t2h, file_byte = '0;
  logic          h2t_valid = 0, h2t_ready, t2h_valid, t2h_ready = 1, sof_tick = 0;
  logic          file_valid = 0, file_ready, sin, sout, lse, ok;
  logic [7:0]    d;
  int            err_total = 0, n_checks = 0, t0, t1, bc;
  usub_byte_type rxq[$];

  assign hready = hreadyout;
  always #5 clk = ~clk;
  // host drains the pipe whenever t2h_ready is high
  always @(posedge clk) if (t2h_valid && t2h_ready) rxq.push_back(t2h);

  usub_bridge dut_u (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .h2t(h2t), .h2t_valid(h2t_valid), .h2t_ready(h2t_ready), .t2h(t2h), .t2h_valid(t2h_valid),
    .t2h_ready(t2h_ready), .sof_tick(sof_tick), .file_byte(file_byte), .file_valid(file_valid),
    .file_ready(file_ready), .bridge_serial_in_pin(sin), .bridge_serial_out_pin(sout), .level_shift_en(lse));
  usub_target tgt_u (.clk(clk), .serial_out(sout), .serial_in(sin));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task conclude;
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // wait for a flag under a bound, give up the run when it never comes
  task automatic hold(ref logic f);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (f !== 1'b1 && n < 5000);
    if (f !== 1'b1)
    begin
      chk("timeout", 0, 1);
      conclude;
    end
  endtask

  task ahb(input logic w, input logic [7:0] a, input logic [31:0] dat, output logic [31:0] rd_data);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hold(hready);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= dat;
    hold(hready);
    rd_data = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] dat);
    logic [31:0] x;
    ahb(1'b1, a, dat, x);
  endtask

  // caller lowers the strobe after the last byte
  task hbyte(input logic [7:0] b, input logic l);
    h2t <= '{last: l, data: b};
    h2t_valid <= 1;
    hold(h2t_ready);
  endtask

  task fbyte(input logic [7:0] b, input logic l);
    file_byte <= '{last: l, data: b};
    file_valid <= 1;
    hold(file_ready);
  endtask

  task sofs(input int n);
    repeat (n)
    begin
      sof_tick <= 1;
      @(posedge clk);
      sof_tick <= 0;
      repeat (2) @(posedge clk);
    end
  endtask

  // run limit
  initial
  begin
    repeat (100000) @(posedge clk);
    chk("run_limit", 0, 1);
    conclude;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    ahb(0, REG_BAUD, 0, r); chk("baud_rst", r, {13'h0, BAUD_DEF});
    ahb(0, REG_STAT, 0, r); chk("stat_rst", r, 0);
    chk("h2t_ready_idle", h2t_ready, 0);
    chk("lse_idle", lse, 0);
    chk("hresp", hresp, 0);
    wr(REG_BAUD, 32'h10); ahb(0, REG_BAUD, 0, r); chk("baud_lo", r, {13'h0, BAUD_MIN});
    wr(REG_BAUD, 32'hfffff); ahb(0, REG_BAUD, 0, r); chk("baud_hi", r, {13'h0, BAUD_MAX});
    wr(REG_FMT, 32'h6); ahb(0, REG_FMT, 0, r); chk("fmt_rb", r, 32'h6);
    ahb(0, 8'h10, 0, r); chk("unmapped", r, 0);
    wr(REG_CTRL, 1); ahb(0, REG_STAT, 0, r); chk("stat_open", r[1:0], 2'h3);
    chk("h2t_ready_open", h2t_ready, 1);
    // every parity, both stop counts, rate changed in session
    for (int i = 0; i < 3; i++)
    begin
      bc = (i == 1) ? 400 : 200;
      wr(REG_BAUD, 100_000_000 / bc);
      wr(REG_FMT, i | ((i == 1) ? 4 : 0));
      hbyte(8'h5a + i, 0);
      hbyte(8'hc3, 1);
      h2t_valid <= 0;
      tgt_u.recv(bc, i, i == 1, d, ok, t0); chk("fmt_d0", {d, ok}, {8'h5a + i, 1'b1});
      tgt_u.recv(bc, i, i == 1, d, ok, t1); chk("fmt_d1", {d, ok}, {8'hc3, 1'b1});
      chk("char_len", (t1 - t0 >= bc * (10 + (i > 0) + (i == 1))) && (t1 - t0 <= bc * (10 + (i > 0) + (i == 1)) + 2), 1);
    end
    // the first frame frees its slot once on the wire; four more queued throttle the host
    fork
      begin
        for (int j = 0; j < 5; j++) hbyte(8'h30 + j, 1);
        h2t_valid <= 0;
        repeat (2) @(posedge clk);
        chk("throttle", h2t_ready, 0);
      end
      for (int j = 0; j < 5; j++)
      begin
        tgt_u.recv(200, PAR_EVEN, 0, d, ok, t0); chk("q_order", {d, ok}, {8'h30 + j, 1'b1});
      end
    join
    // partial receive frame waits for the flush tick count
    for (int k = 0; k < 3; k++) tgt_u.send(200, PAR_EVEN, 0, 8'ha0 + k);
    sofs(99); chk("no_flush", rxq.size(), 0);
    sofs(1);
    repeat (10) @(posedge clk);
    chk("flush_n", rxq.size(), 3);
    for (int k = 0; k < 3 && k < rxq.size(); k++) chk("t2h", rxq[k], {k == 2, 8'(8'ha0 + k)});
    rxq.delete();
    // closing the session still drains a queued frame
    fork
      begin
        hbyte(8'h77, 1);
        h2t_valid <= 0;
        wr(REG_CTRL, 0);
      end
      begin
        tgt_u.recv(200, PAR_EVEN, 0, d, ok, t0); chk("drain", {d, ok}, {8'h77, 1'b1});
      end
    join
    ahb(0, REG_STAT, 0, r); chk("stat_closed", r[1:0], 2'h2);
    chk("lse_kept", lse, 1);
    chk("refuse", h2t_ready, 0);
    tgt_u.send(200, PAR_EVEN, 0, 8'h11);
    sofs(100);
    chk("rx_off", rxq.size(), 0);
    // file override at the last used rate
    for (int j = 0; j < PREFIX_LEN; j++) fbyte(PREFIX[111 - 8 * j -: 8], 0);
    fbyte(8'h48, 0);
    fbyte(8'h69, 1);
    file_valid <= 0;
    tgt_u.recv(200, PAR_EVEN, 0, d, ok, t0); chk("ovr0", {d, ok}, {8'h48, 1'b1});
    tgt_u.recv(200, PAR_EVEN, 0, d, ok, t0); chk("ovr1", {d, ok}, {8'h69, 1'b1});
    repeat (300) @(posedge clk);
    chk("file_ready", file_ready, 1);
    // stalled host: the ninth one-byte frame finds seven queued and is recycled
    wr(REG_CTRL, 1);
    t2h_ready <= 0;
    for (int k = 0; k < 9; k++)
    begin
      tgt_u.send(200, PAR_EVEN, 0, 8'h40 + k);
      sofs(100);
    end
    ahb(0, REG_STAT, 0, r); chk("ovr_stat", {r[15:12], r[2]}, {4'h7, 1'b1});
    t2h_ready <= 1;
    repeat (40) @(posedge clk);
    chk("ovr_n", rxq.size(), 8);
    chk("ovr_last", rxq[7], {1'b1, 8'h47});
    wr(REG_STAT, 32'h4); ahb(0, REG_STAT, 0, r); chk("ovr_clr", r[2], 0);
    conclude;
  end
endmodule
